/* hw/pwfm_defs.svh */
// register offsets, field positions, reset values and timing counts of the measure block
`ifndef PWFM_DEFS_SVH
`define PWFM_DEFS_SVH
`define PWFM_ADDR_W        8
`define PWFM_OFF_CTRL1     8'h00
`define PWFM_OFF_CTRL2     8'h04
`define PWFM_OFF_COUNT     8'h08
`define PWFM_OFF_GATEPER   8'h0c
`define PWFM_OFF_STATUS    8'h10
`define PWFM_CNT_W         18
`define PWFM_CNT_MAX       18'h3ffff
`define PWFM_START_RUN     2'h2
`define PWFM_START_STOP    2'h0
`define PWFM_CTRL1_RST     6'h00
`define PWFM_CTRL2_RST     6'h00
`define PWFM_GATEPER_RST   8'h00
`define PWFM_GATE_SPAN     5'h10
`define PWFM_FC_UNIT_LOG2  12
`define PWFM_FS_UNIT_LOG2  4
`define PWFM_DIV_W         16
`define PWFM_FSDIV_W       8
`define PWFM_SRC1_BIT      4'h2
`define PWFM_SRC2_BIT      4'h6
`define PWFM_SRC3_BIT      4'ha
`endif

/* hw/pwfm_pkg.sv */
// types shared by the pulse width / frequency measure block
package pwfm_pkg;
    // gate generator states, gray along idle-sync-high-low
    typedef enum logic [1:0] {
        GATE_IDLE = 2'b00,
        GATE_SYNC = 2'b01,
        GATE_HIGH = 2'b11,
        GATE_LOW  = 2'b10
    } pwfm_gate_st_t;

    // control register one fields
    typedef struct packed {
        logic       freqMode;   // 0 pulse width, 1 frequency
        logic [1:0] srcSel;     // 0 external, 1..3 internal clocks
        logic [1:0] startCtl;   // 00 stop, 10 run
        logic       clearBit;   // reads as zero
    } pwfm_ctrl1_t;

    // control register two fields
    typedef struct packed {
        logic       divStageSel;
        logic [1:0] gatePsc;
        logic [1:0] gateSrcSel;
        logic       gateIrqEdgeSel;  // 0 falling, 1 both
    } pwfm_ctrl2_t;

    // gate period settings
    typedef struct packed {
        logic [3:0] gateLowSetting;
        logic [3:0] gateHighSetting;
    } pwfm_gateper_t;
endpackage

/* hw/pwfm_top.sv */
// pulse width and frequency measurement timer with apb register access
//
// Behaviour
// RULE_01: pulse width mode counts falling edges of event input AND selected internal clock.
// RULE_02: software picks internal clock for pulse width, external source for frequency.
// RULE_03: pulse width mode interrupts on event falling edge, or both edges if selected.
// RULE_04: without a clear, counting resumes from the value held when it last stopped.
// RULE_05: counter wrapping from maximum to zero sets the overflow flag.
// RULE_06: overflow flag holds until software writes the counter clear bit.
// RULE_07: pulse width mode, writing stop while event input high raises interrupt.
// RULE_08: software stops counter then clears its interrupt latch with interrupts disabled.
// RULE_09: pulse width, both edges, writing start while event high raises interrupt.
// RULE_10: gate status monitor is meaningless in pulse width mode.
// RULE_11: event falling while internal clock high gives one extra count.
// RULE_12: frequency mode counts event edges only while the window gate is high.
// RULE_13: gate source select 00 uses the external gate pin, else internal generator.
// RULE_14: frequency mode interrupts on gate falling edge, or both edges if selected.
// RULE_15: software reads count while stopped and gate low, then clears the counter.
// RULE_16: frequency mode shows the current window gate level in the monitor bit.
// RULE_17: internal gate high and low periods each last sixteen minus setting units.
// RULE_18: gate unit is 2^12..2^14 fc cycles, or 2^4..2^6 fs cycles; here gatePsc 3 also gives 2^15 fc or 2^7 fs cycles.
// RULE_19: one internal gate cycle is high period followed by low period.
// RULE_20: internal gate aligns to the divider, first period may lag one unit.
// RULE_21: gate settings change only stopped or in low; low setting applies next low.
// RULE_22: gate falling while event high adds one count.
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
`include "pwfm_defs.svh"

module pwfm_top #(
    parameter int CNT_W = `PWFM_CNT_W
) (
    // clock and reset
    input  wire logic                     mclk,
    input  wire logic                     rstn,
    // apb slave
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [`PWFM_ADDR_W-1:0]  paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    // pins
    input  wire logic                     eventInputPin,
    input  wire logic                     externalGateInput,
    input  wire logic                     lowSpeedClk,
    // event output
    output logic                          timerIrq
);

    // software state
    pwfm_pkg::pwfm_ctrl1_t   controlRegisterOne_reg;
    pwfm_pkg::pwfm_ctrl2_t   controlRegisterTwo_reg;
    pwfm_pkg::pwfm_gateper_t gatePeriodRegister_reg;
    logic [CNT_W-1:0]        countRegister_reg;
    logic                    overflowFlag_reg;
    logic                    prready_reg;
    logic [31:0]             prdata_reg;
    logic                    pslverr_reg;
    logic                    timerIrq_reg;

    // pin synchronisers and edge history
    logic [1:0]              eventSync_reg;
    logic [1:0]              gateSync_reg;
    logic [1:0]              fsSync_reg;
    logic                    eventPrev_reg;
    logic                    fsPrev_reg;

    // dividers and gate generator
    logic [`PWFM_DIV_W-1:0]   divCnt_reg;
    logic [`PWFM_DIV_W-1:0]   divPrev_reg;
    logic [`PWFM_FSDIV_W-1:0] fsDiv_reg;
    logic [`PWFM_FSDIV_W-1:0] fsDivPrev_reg;
    pwfm_pkg::pwfm_gate_st_t  gateState_reg;
    logic [3:0]               unitCnt_reg;
    logic                     gatePrev_reg;
    logic                     andPrev_reg;

    // combinational helpers
    logic                     eventLvl;
    logic                     gateLvl;
    logic                     internalGate;
    logic                     srcClkLvl;
    logic                     andLvl;
    logic                     countTick;
    logic                     unitTick;
    logic                     fsRise;
    logic                     running;
    logic                     apbWrite;
    logic                     apbSetup;
    logic                     clearReq;
    logic                     startWrite;
    logic                     stopWrite;
    pwfm_pkg::pwfm_ctrl1_t    wrCtrl1;

    // true when a divider bit goes from one to zero
    function automatic logic bitFall(input logic [15:0] prevVal,
                                     input logic [15:0] curVal,
                                     input logic [3:0]  idx);
        bitFall = prevVal[idx] & ~curVal[idx];
    endfunction

    // register hits
    function automatic logic hit(input logic [`PWFM_ADDR_W-1:0] addr,
                                 input logic [`PWFM_ADDR_W-1:0] off);
        hit = (addr == off);
    endfunction

    assign eventLvl   = eventSync_reg[1];
    assign running    = (controlRegisterOne_reg.startCtl == `PWFM_START_RUN);
    assign apbSetup   = psel & ~penable;
    assign apbWrite   = psel & penable & prready_reg & pwrite;
    assign wrCtrl1    = pwdata[5:0];
    assign clearReq   = apbWrite & hit(paddr, `PWFM_OFF_CTRL1) & wrCtrl1.clearBit;
    assign startWrite = apbWrite & hit(paddr, `PWFM_OFF_CTRL1)
                        & (wrCtrl1.startCtl == `PWFM_START_RUN);
    assign stopWrite  = apbWrite & hit(paddr, `PWFM_OFF_CTRL1)
                        & (wrCtrl1.startCtl == `PWFM_START_STOP);
    assign fsRise     = fsSync_reg[1] & ~fsPrev_reg;

    // internal source clock level; select 0 is the external clock, unused here
    always_comb begin
        case (controlRegisterOne_reg.srcSel)
            2'h1:    srcClkLvl = divCnt_reg[`PWFM_SRC1_BIT];
            2'h2:    srcClkLvl = divCnt_reg[`PWFM_SRC2_BIT];
            2'h3:    srcClkLvl = divCnt_reg[`PWFM_SRC3_BIT];
            default: srcClkLvl = 1'b0;
        endcase
    end

    // gate unit tick: fc path or fs path of the divider
    always_comb begin
        if (!controlRegisterTwo_reg.divStageSel) begin
            unitTick = bitFall(divPrev_reg, divCnt_reg,
                               4'(`PWFM_FC_UNIT_LOG2 - 1) + 4'(controlRegisterTwo_reg.gatePsc)); // RULE_18
        end else begin
            unitTick = bitFall(16'(fsDivPrev_reg), 16'(fsDiv_reg),
                               4'(`PWFM_FS_UNIT_LOG2 - 1) + 4'(controlRegisterTwo_reg.gatePsc)); // RULE_18
        end
    end

    // window gate source and the counted and-ed level
    assign internalGate = (gateState_reg == pwfm_pkg::GATE_HIGH);
    assign gateLvl = (controlRegisterTwo_reg.gateSrcSel == 2'h0) ? gateSync_reg[1] // RULE_13
                                                                  : internalGate;
    always_comb begin
        if (controlRegisterOne_reg.freqMode) begin
            andLvl = eventLvl & gateLvl; // RULE_12
        end else begin
            andLvl = eventLvl & srcClkLvl; // RULE_01
        end
    end
    // falling edge of the and, so a late fall adds one count
    assign countTick = running & andPrev_reg & ~andLvl; // RULE_11 RULE_22

    // two-flop synchronisers on every pin
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            eventSync_reg <= 2'h0;
            gateSync_reg  <= 2'h0;
            fsSync_reg    <= 2'h0;
        end else begin
            eventSync_reg <= {eventSync_reg[0], eventInputPin};
            gateSync_reg  <= {gateSync_reg[0], externalGateInput};
            fsSync_reg    <= {fsSync_reg[0], lowSpeedClk};
        end
    end

    // edge history of synchronised and derived levels
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            eventPrev_reg <= 1'b0;
            fsPrev_reg    <= 1'b0;
            gatePrev_reg  <= 1'b0;
            andPrev_reg   <= 1'b0;
        end else begin
            eventPrev_reg <= eventLvl;
            fsPrev_reg    <= fsSync_reg[1];
            gatePrev_reg  <= gateLvl;
            andPrev_reg   <= andLvl;
        end
    end

    // free running chip dividers, fc and fs
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            divCnt_reg    <= '0;
            divPrev_reg   <= '0;
            fsDiv_reg     <= '0;
            fsDivPrev_reg <= '0;
        end else begin
            divCnt_reg    <= divCnt_reg + 1'b1;
            divPrev_reg   <= divCnt_reg;
            fsDivPrev_reg <= fsDiv_reg;
            if (fsRise) begin
                fsDiv_reg <= fsDiv_reg + 1'b1;
            end
        end
    end

    // internal gate: high for (16-high) units, then low for (16-low) units
    // counting up from the setting to 15 avoids a subtractor
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            gateState_reg <= pwfm_pkg::GATE_IDLE;
            unitCnt_reg   <= 4'h0;
        end else if (!running || !controlRegisterOne_reg.freqMode) begin
            gateState_reg <= pwfm_pkg::GATE_IDLE;
            unitCnt_reg   <= 4'h0;
        end else begin
            case (gateState_reg)
                pwfm_pkg::GATE_IDLE: begin
                    gateState_reg <= pwfm_pkg::GATE_SYNC;
                end
                pwfm_pkg::GATE_SYNC: begin
                    // waits for the next unit boundary, up to one unit of lag
                    if (unitTick) begin // RULE_20
                        gateState_reg <= pwfm_pkg::GATE_HIGH;
                        unitCnt_reg   <= gatePeriodRegister_reg.gateHighSetting; // RULE_17
                    end
                end
                pwfm_pkg::GATE_HIGH: begin
                    if (unitTick) begin
                        if (unitCnt_reg == 4'hf) begin
                            gateState_reg <= pwfm_pkg::GATE_LOW; // RULE_19
                            unitCnt_reg   <= gatePeriodRegister_reg.gateLowSetting; // RULE_17
                        end else begin
                            unitCnt_reg <= unitCnt_reg + 4'h1;
                        end
                    end
                end
                pwfm_pkg::GATE_LOW: begin
                    // low length latched at entry, a new write waits for the next low
                    if (unitTick) begin
                        if (unitCnt_reg == 4'hf) begin
                            gateState_reg <= pwfm_pkg::GATE_HIGH; // RULE_19
                            unitCnt_reg   <= gatePeriodRegister_reg.gateHighSetting; // RULE_21
                        end else begin
                            unitCnt_reg <= unitCnt_reg + 4'h1;
                        end
                    end
                end
                default: begin
                    gateState_reg <= pwfm_pkg::GATE_IDLE;
                end
            endcase
        end
    end

    // up counter; holds its value when stopped so counting resumes
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            countRegister_reg <= '0;
        end else if (clearReq) begin
            countRegister_reg <= '0;
        end else if (countTick) begin
            countRegister_reg <= countRegister_reg + 1'b1; // RULE_04
        end
    end

    // overflow flag; a wrap in the clear cycle still sets it
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            overflowFlag_reg <= 1'b0;
        end else if (countTick && countRegister_reg == CNT_W'(`PWFM_CNT_MAX)) begin
            overflowFlag_reg <= 1'b1; // RULE_05
        end else if (clearReq) begin
            overflowFlag_reg <= 1'b0; // RULE_06
        end
    end

    // timer interrupt pulse, one cycle per event
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            timerIrq_reg <= 1'b0;
        end else if (controlRegisterOne_reg.freqMode) begin
            timerIrq_reg <= running & ((gatePrev_reg & ~gateLvl)
                            | (controlRegisterTwo_reg.gateIrqEdgeSel
                               & ~gatePrev_reg & gateLvl)); // RULE_14
        end else begin
            timerIrq_reg <= (running & ((eventPrev_reg & ~eventLvl)
                             | (controlRegisterTwo_reg.gateIrqEdgeSel
                                & ~eventPrev_reg & eventLvl))) // RULE_03
                            | (stopWrite & running & eventLvl) // RULE_07
                            | (startWrite & ~running & eventLvl
                               & controlRegisterTwo_reg.gateIrqEdgeSel); // RULE_09
        end
    end

    // apb register writes; clear bit is a strobe and never stored
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            controlRegisterOne_reg <= `PWFM_CTRL1_RST;
            controlRegisterTwo_reg <= `PWFM_CTRL2_RST;
            gatePeriodRegister_reg <= `PWFM_GATEPER_RST;
        end else if (apbWrite) begin
            if (hit(paddr, `PWFM_OFF_CTRL1)) begin
                controlRegisterOne_reg          <= wrCtrl1;
                controlRegisterOne_reg.clearBit <= 1'b0;
            end
            if (hit(paddr, `PWFM_OFF_CTRL2)) begin
                controlRegisterTwo_reg <= pwdata[5:0];
            end
            // no guard against writes in the high period: software's duty
            if (hit(paddr, `PWFM_OFF_GATEPER)) begin
                gatePeriodRegister_reg <= pwdata[7:0]; // RULE_21
            end
        end
    end

    // apb answer: no wait state, read data captured in the setup cycle
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            prready_reg <= 1'b0;
            prdata_reg  <= 32'h0;
            pslverr_reg <= 1'b0;
        end else begin
            prready_reg <= apbSetup;
            pslverr_reg <= apbSetup & ~(hit(paddr, `PWFM_OFF_CTRL1)
                           | hit(paddr, `PWFM_OFF_CTRL2) | hit(paddr, `PWFM_OFF_COUNT)
                           | hit(paddr, `PWFM_OFF_GATEPER) | hit(paddr, `PWFM_OFF_STATUS));
            if (apbSetup && !pwrite) begin
                case (paddr)
                    `PWFM_OFF_CTRL1:   prdata_reg <= {26'h0, controlRegisterOne_reg};
                    `PWFM_OFF_CTRL2:   prdata_reg <= {26'h0, controlRegisterTwo_reg};
                    `PWFM_OFF_COUNT:   prdata_reg <= 32'(countRegister_reg);
                    `PWFM_OFF_GATEPER: prdata_reg <= {24'h0, gatePeriodRegister_reg};
                    // monitor forced low in pulse width mode, it has no meaning there
                    `PWFM_OFF_STATUS:  prdata_reg <= {30'h0,
                                           controlRegisterOne_reg.freqMode & gateLvl, // RULE_16 RULE_10
                                           overflowFlag_reg};
                    default:           prdata_reg <= 32'h0;
                endcase
            end else begin
                prdata_reg <= 32'h0;
            end
        end
    end

    assign prdata   = prdata_reg;
    assign pready   = prready_reg;
    assign pslverr  = pslverr_reg;
    assign timerIrq = timerIrq_reg;

endmodule

/* tb/pwfm_top_assertions.sv */
// port checks of the measure block, bound into its top
`timescale 1ns/100ps
`include "pwfm_defs.svh"
module pwfm_top_chk #(
    parameter int CNT_W = 18
) (
    // clock and reset
    input wire logic                    mclk,
    input wire logic                    rstn,
    // apb
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [`PWFM_ADDR_W-1:0] paddr,
    input wire logic [31:0]             pwdata,
    input wire logic [31:0]             prdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    // pins
    input wire logic                    eventInputPin,
    input wire logic                    externalGateInput,
    input wire logic                    lowSpeedClk,
    input wire logic                    timerIrq
);
    logic [5:0] c1Reg;
    logic [5:0] c2Reg;
    logic [3:0] stopCnt;
    wire logic  wrOk   = psel && penable && pready && pwrite;
    wire logic  ctlWr  = wrOk && paddr == `PWFM_OFF_CTRL1;
    wire logic  runNow = c1Reg[2:1] == `PWFM_START_RUN;
    wire logic  pwRun  = runNow && !c1Reg[5];
    // mirror control writes so the checks know the mode
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) c1Reg <= 6'h00;
        else if (ctlWr) c1Reg <= pwdata[5:0];
    end
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) c2Reg <= 6'h00;
        else if (wrOk && paddr == `PWFM_OFF_CTRL2) c2Reg <= pwdata[5:0];
    end
    // cycles spent stopped, saturating so it never wraps
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) stopCnt <= 4'h0;
        else stopCnt <= runNow ? 4'h0 : (stopCnt == 4'hf ? stopCnt : stopCnt + 4'h1);
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_irq_soon;
        ##[2:6] timerIrq;
    endsequence
    a_ready_after_setup: assert property (s_setup |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_reply_error_map: assert property (pready
        |-> pslverr == (paddr > `PWFM_OFF_STATUS || paddr[1:0] != 2'h0))
        else $error("error flag wrong for address");
    a_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    a_pw_fall_irq: assert property (pwRun && $fell(eventInputPin) |-> s_irq_soon)
        else $error("no irq on event fall");
    a_pw_rise_irq: assert property (pwRun && c2Reg[0] && $rose(eventInputPin)
        |-> s_irq_soon) else $error("no irq on event rise");
    a_stop_high_irq: assert property (ctlWr && pwdata[2:1] == `PWFM_START_STOP
        && pwRun && eventInputPin |-> ##[1:5] timerIrq) else $error("no irq on stop");
    a_start_high_irq: assert property (ctlWr && pwdata[2:1] == `PWFM_START_RUN
        && !pwdata[5] && !runNow && c2Reg[0] && eventInputPin |-> ##[1:5] timerIrq)
        else $error("no irq on start");
    a_gate_fall_irq: assert property (runNow && c1Reg[5] && c2Reg[2:1] == 2'h0
        && $fell(externalGateInput) |-> s_irq_soon) else $error("no irq on gate fall");
    a_quiet_stopped: assert property (c1Reg[5] && stopCnt == 4'hf |-> !timerIrq)
        else $error("irq while stopped");
endmodule

bind pwfm_top pwfm_top_chk #(.CNT_W(CNT_W)) u_chk (
    .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .eventInputPin(eventInputPin), .externalGateInput(externalGateInput),
    .lowSpeedClk(lowSpeedClk), .timerIrq(timerIrq)
);

/* tb/pwfm_pin_source.sv */
// far-side pin model: event level, external gate and free slow clock
`timescale 1ns/100ps
module pwfm_pin_source (
    // bench clock
    input  wire logic mclk,
    // pins toward the block
    output logic      eventInputPin,
    output logic      externalGateInput,
    output logic      lowSpeedClk
);
    logic fsPh = 1'b0;
    initial begin
        eventInputPin = 1'b0;
        externalGateInput = 1'b0;
        lowSpeedClk = 1'b0;
    end
    // slow clock at a quarter of mclk, free running like a chip clock
    always @(posedge mclk) begin
        fsPh <= !fsPh;
        if (fsPh) lowSpeedClk <= !lowSpeedClk;
    end
    // pins change just after an edge and hold until the next call
    task automatic set_pins(input logic ev, input logic gt);
        eventInputPin <= ev;
        externalGateInput <= gt;
    endtask
endmodule

/* tb/tb_top.sv */
// self-checking bench for the pulse width / frequency measure block
`timescale 1ns/100ps
`include "pwfm_defs.svh"
module tb_top;
    localparam int UNIT = 16 * 4;
    logic        mclk, rstn, psel, penable, pwrite, pready, pslverr, timerIrq;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        evPin;
    logic        gatePin;
    logic        fsClk;
    logic [33:0] expQ[$];
    int          irqAt[$];
    int          cyc, failCount, checks, seed;

    pwfm_top #(.CNT_W(8)) u_dut ( // narrow counter so a wrap fits the run
        .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .eventInputPin(evPin), .externalGateInput(gatePin), .lowSpeedClk(fsClk),
        .timerIrq(timerIrq)
    );
    pwfm_pin_source u_src (
        .mclk(mclk), .eventInputPin(evPin), .externalGateInput(gatePin), .lowSpeedClk(fsClk)
    );
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checks++;
        if (seen !== exp) begin
            failCount++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks=%0d failCount=%0d", checks, failCount);
        if (failCount == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // answer monitor, interrupt log and run limit
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (pready === 1'b1 && pwrite === 1'b0 && expQ.size() > 0) begin
            if (expQ[0][33]) check({pslverr, prdata}, expQ[0][32:0]);
            void'(expQ.pop_front());
        end
        if (timerIrq === 1'b1) irqAt.push_back(cyc);
        if (cyc == 40000) begin
            failCount++;
            give_verdict();
        end
    end
    // one transfer; an idle edge at the end keeps strobes from colliding
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk);
        while (pready !== 1'b1);
        q = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        logic [31:0] q;
        expQ.push_back({1'b1, e});
        apb(1'b0, a, 32'h0, q);
    endtask
    task automatic rdq(input logic [7:0] a, output logic [31:0] q);
        expQ.push_back(34'h0);
        apb(1'b0, a, 32'h0, q);
    endtask
    task automatic pulse(input int len);
        u_src.set_pins(1'b1, 1'b0);
        repeat (len) @(posedge mclk);
        u_src.set_pins(1'b0, 1'b0);
        repeat (20) @(posedge mclk);
    endtask
    initial begin
        logic [31:0] v, q1, q2;
        int          b;
        {seed, failCount, checks, cyc} = {32'd85, 32'd0, 32'd0, 32'd0};
        {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        // reset values, then an unmapped place that must refuse
        for (int i = 0; i < 5; i++) rd(8'(4 * i), 33'h0);
        rd(8'h14, 33'h1_0000_0000);
        // random settings round trip while stopped
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            wr(`PWFM_OFF_GATEPER, v);
            rd(`PWFM_OFF_GATEPER, {25'h0, v[7:0]});
            wr(`PWFM_OFF_CTRL2, v);
            rd(`PWFM_OFF_CTRL2, {27'h0, v[5:0]});
        end
        wr(`PWFM_OFF_CTRL1, 32'h09);
        rd(`PWFM_OFF_CTRL1, 33'h08);
        // pulse width, falling-edge irq, mclk/8 source
        wr(`PWFM_OFF_CTRL2, 32'h00);
        wr(`PWFM_OFF_CTRL1, 32'h0c);
        pulse(80);
        rdq(`PWFM_OFF_COUNT, q1);
        check({32'h0, q1 >= 9 && q1 <= 11}, 33'h1);
        pulse(80);
        rdq(`PWFM_OFF_COUNT, q2);
        check({32'h0, q2 >= q1 + 9 && q2 <= q1 + 11}, 33'h1);
        check(33'(irqAt.size()), 33'h2);
        // stop while high, then start while high with both edges
        u_src.set_pins(1'b1, 1'b0);
        repeat (20) @(posedge mclk);
        wr(`PWFM_OFF_CTRL1, 32'h08);
        repeat (10) @(posedge mclk);
        check(33'(irqAt.size()), 33'h3);
        wr(`PWFM_OFF_CTRL2, 32'h01);
        wr(`PWFM_OFF_CTRL1, 32'h0c);
        repeat (10) @(posedge mclk);
        check(33'(irqAt.size()), 33'h4);
        u_src.set_pins(1'b0, 1'b0);
        repeat (20) @(posedge mclk);
        pulse(2100);
        rd(`PWFM_OFF_STATUS, 33'h1);
        wr(`PWFM_OFF_CTRL1, 32'h09);
        rd(`PWFM_OFF_COUNT, 33'h0);
        rd(`PWFM_OFF_STATUS, 33'h0);
        check(33'(irqAt.size()), 33'h7);
        // frequency mode on the external gate pin
        wr(`PWFM_OFF_CTRL2, 32'h00);
        wr(`PWFM_OFF_CTRL1, 32'h25);
        u_src.set_pins(1'b1, 1'b0);
        repeat (10) @(posedge mclk);
        u_src.set_pins(1'b1, 1'b1);
        repeat (10) @(posedge mclk);
        rd(`PWFM_OFF_STATUS, 33'h2);
        u_src.set_pins(1'b1, 1'b0);
        repeat (10) @(posedge mclk);
        rd(`PWFM_OFF_COUNT, 33'h1);
        check(33'(irqAt.size()), 33'h8);
        // ten event falls inside a window, five outside it
        u_src.set_pins(1'b1, 1'b1);
        for (int i = 0; i < 15; i++) begin
            repeat (4) @(posedge mclk);
            u_src.set_pins(1'b0, i < 10);
            repeat (4) @(posedge mclk);
            u_src.set_pins(1'b1, i < 10);
        end
        wr(`PWFM_OFF_CTRL1, 32'h20);
        rd(`PWFM_OFF_COUNT, 33'h0c);
        rd(`PWFM_OFF_STATUS, 33'h0);
        check(33'(irqAt.size()), 33'h9);
        // internal gate, slow clock units, two high and three low
        wr(`PWFM_OFF_GATEPER, 32'hde);
        wr(`PWFM_OFF_CTRL2, 32'h23);
        b = irqAt.size();
        wr(`PWFM_OFF_CTRL1, 32'h25);
        repeat (1000) @(posedge mclk);
        wr(`PWFM_OFF_CTRL1, 32'h20);
        check(33'(irqAt[b + 1] - irqAt[b]), 33'((16 - 14) * UNIT));
        check(33'(irqAt[b + 2] - irqAt[b + 1]), 33'((16 - 13) * UNIT));
        give_verdict();
    end
endmodule
